//--- logic/vdd_pkg.sv
// Package for the valve driver discrete I/O block.
// Assumes a 20 MHz single clock and an AXI4-Lite register bus.
package vdd_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_CONFIG    = 8'h00;
    localparam logic [7:0]  OFS_SW_OUT    = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
    // Config fields
    localparam int CFG_EN_AS_GPI   = 0;
    localparam int CFG_FLT_AS_GPO  = 1;
    localparam int CFG_GRAY        = 2;
    localparam int CFG_XDCR_CUR    = 3;
    localparam int CFG_W           = 4;
    // Status fields
    localparam int ST_ENABLE       = 0;
    localparam int ST_DRIVE        = 1;
    localparam int ST_FAULT        = 2;
    localparam int ST_SEL0         = 3;
    localparam int ST_SEL1         = 4;
    localparam int ST_PID_LSB      = 5;
    localparam int ST_W            = 7;
    // Event bits
    localparam int EV_ENABLE_CHG   = 0;
    localparam int EV_FAULT_SET    = 1;
    localparam int EV_PID_CHG      = 2;
    localparam int EV_W            = 3;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int CLK_HZ          = 20_000_000;
    localparam int DEBOUNCE_US     = 50;
    localparam int DEBOUNCE_CYC    = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int DB_W            = 11;
    localparam int NUM_IN          = 3;
endpackage

//--- logic/vdd_debounce.sv
// Synchroniser and debouncer for one on-off input pin.
// Assumes the pin is asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module vdd_debounce
    import vdd_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic pin,
    output var  logic level,
    output var  logic changed
);
    typedef struct packed {
        logic [2:0]      sync;
        logic [DB_W-1:0] cnt;
        logic            level;
        logic            changed;
    } vdd_db_t;
    vdd_db_t st;
    vdd_db_t next_st;

    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[1:0], pin};
        next_st.changed = 1'b0;
        // Count only stable agreement of stages two and three [RULE15]
        if (st.sync[1] != st.sync[2] || st.sync[2] == st.level) begin
            next_st.cnt = '0;
        end else if (st.cnt == DB_W'(DEBOUNCE_CYC - 1)) begin
            next_st.cnt = '0;
            next_st.level = st.sync[2];
            next_st.changed = 1'b1;
        end else begin
            next_st.cnt = st.cnt + DB_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign changed = st.changed;

    a_level_stable: assert property (@(posedge CLK) disable iff (RST) // [RULE15]
        !changed |=> $stable(level) || changed)
        else $error("Debounced level moved without a change pulse");
endmodule
`default_nettype wire

//--- logic/vdd_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a compliant master; exposes simple word strobes to the core.
`timescale 1ns/1ps
`default_nettype none
module vdd_axil_slave
    import vdd_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]      wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_ok,
    output logic                   rd_stb,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              rd_ok
);
    typedef struct packed {
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] awa;
        logic [DATA_W-1:0] wd;
        logic [3:0]        ws;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } vdd_ax_t;
    vdd_ax_t st;
    vdd_ax_t next_st;

    assign awready = !st.aw_have && !st.bvalid;
    assign wready  = !st.w_have && !st.bvalid;
    assign arready = !st.rvalid;
    assign wr_stb  = st.aw_have && st.w_have && !st.bvalid;
    assign wr_addr = st.awa;
    assign wr_data = st.wd;
    assign wr_strb = st.ws;
    assign rd_stb  = arvalid && arready;
    assign rd_addr = araddr;

    always_comb begin
        next_st = st;
        if (awvalid && awready) begin
            next_st.aw_have = 1'b1;
            next_st.awa = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_have = 1'b1;
            next_st.wd = wdata;
            next_st.ws = wstrb;
        end
        if (wr_stb) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (rd_stb) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_data;
            next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bvalid = st.bvalid;
    assign bresp  = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata  = st.rdata;
    assign rresp  = st.rresp;
endmodule
`default_nettype wire

//--- logic/vdd_top.sv
// Discrete on-off I/O of a proportional valve driver with AXI4-Lite registers.
// Assumes 24 V pins are level-shifted to logic; fault detectors are plain levels.
// Function
// RULE1: Solenoid current flows only while enable input is high.
// RULE2: Low enable stops only solenoid drive; registers and monitoring stay live.
// RULE3: Config bit reassigns enable as generic input that no longer gates drive.
// RULE4: Basic variant repeats the enable level on a repeat output.
// RULE5: Fault output low while any fault present, high when healthy.
// RULE6: Faults: solenoid short/open, reference break in current range, transducer break.
// RULE7: Fault is computed independently of the enable input.
// RULE8: Config bit turns fault line into software-driven digital output.
// RULE9: Binary select: 00 set1, 01 set2, 10 set3, 11 set4.
// RULE10: Config bit switches select interpretation to Gray coding.
// RULE11: Active PID set follows select changes while running.
// RULE12: Dual-transducer force variant ignores second select input.
// RULE13: Transducer range bit selects voltage or current, default from option.
// RULE14: Gray select: 00 set1, 01 set2, 11 set3, 10 set4.
// RULE15: Each on-off input is synchronised and debounced before use.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vdd_top
    import vdd_pkg::*;
#(
    parameter logic BASIC_VARIANT                 = 1'b1,
    parameter logic DUAL_TRANSDUCER_FORCE_VARIANT = 1'b0,
    parameter logic XDCR_CURRENT_OPTION           = 1'b0
)
(
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic [vdd_pkg::ADDR_W-1:0] AWADDR,
    input  wire logic                       AWVALID,
    output logic                            AWREADY,
    input  wire logic [vdd_pkg::DATA_W-1:0] WDATA,
    input  wire logic [3:0]                 WSTRB,
    input  wire logic                       WVALID,
    output logic                            WREADY,
    output logic [1:0]                      BRESP,
    output logic                            BVALID,
    input  wire logic                       BREADY,
    input  wire logic [vdd_pkg::ADDR_W-1:0] ARADDR,
    input  wire logic                       ARVALID,
    output logic                            ARREADY,
    output logic [vdd_pkg::DATA_W-1:0]      RDATA,
    output logic [1:0]                      RRESP,
    output logic                            RVALID,
    input  wire logic                       RREADY,
    input  wire logic                       ENABLE_IN,
    input  wire logic                       PID_SELECT_BIT0,
    input  wire logic                       PID_SELECT_BIT1,
    input  wire logic                       SOLENOID_SHORT,
    input  wire logic                       SOLENOID_OPEN,
    input  wire logic                       REF_CABLE_BROKEN,
    input  wire logic                       REF_CURRENT_RANGE,
    input  wire logic                       XDCR_CABLE_BROKEN,
    output logic                            SOLENOID_DRIVE_EN,
    output logic                            REPEAT_ENABLE,
    output logic                            FAULT_OUT,
    output logic [1:0]                      PID_SET,
    output logic                            XDCR_CURRENT_RANGE,
    output logic                            IRQ
);
    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic             sw_out;
        logic [EV_W-1:0]  irq_stat;
        logic [EV_W-1:0]  irq_mask;
        logic             drive;
        logic             rep;
        logic             fault_pin;
        logic             fault_q;
        logic [1:0]       pid;
        logic             seeded;
    } vdd_st_t;
    vdd_st_t st;
    vdd_st_t next_st;

    logic [NUM_IN-1:0] pin_in;
    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] chg;
    logic              wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0]        wr_strb;
    logic              wr_ok;
    logic              rd_stb;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              rd_ok;
    logic              fault_any;
    logic [1:0]        sel;
    logic [1:0]        pid_dec;
    logic [EV_W-1:0]   ev;

    // Decode select lines into set index 0..3
    function automatic logic [1:0] pid_decode(input logic [1:0] s, input logic gray);
        if (gray) begin
            pid_decode = {s[1], s[1] ^ s[0]}; // [RULE14] [RULE10]
        end else begin
            pid_decode = s; // [RULE9]
        end
    endfunction

    assign pin_in = {PID_SELECT_BIT1, PID_SELECT_BIT0, ENABLE_IN};

    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        vdd_debounce u_db (
            .CLK     (CLK),
            .RST     (RST),
            .pin     (pin_in[i]),
            .level   (lvl[i]),
            .changed (chg[i])
        );
    end

    vdd_axil_slave u_bus (
        .CLK     (CLK),
        .RST     (RST),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // Reference break only counts in the current-loop range; no enable term here
    assign fault_any = SOLENOID_SHORT || SOLENOID_OPEN
                     || (REF_CABLE_BROKEN && REF_CURRENT_RANGE)
                     || XDCR_CABLE_BROKEN; // [RULE6] [RULE7]

    // Second select is absent on the dual-transducer force variant
    assign sel = {lvl[2] && !DUAL_TRANSDUCER_FORCE_VARIANT, lvl[1]}; // [RULE12]
    assign pid_dec = pid_decode(sel, st.cfg[CFG_GRAY]);

    assign ev[EV_ENABLE_CHG] = chg[0];
    assign ev[EV_FAULT_SET]  = fault_any && !st.fault_q;
    assign ev[EV_PID_CHG]    = st.seeded && (pid_dec != st.pid);

    always_comb begin
        wr_ok = 1'b1;
        case (wr_addr)
            OFS_CONFIG, OFS_SW_OUT, OFS_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_data = '0;
        case (rd_addr)
            OFS_CONFIG:   rd_data = DATA_W'(st.cfg);
            OFS_SW_OUT:   rd_data = DATA_W'(st.sw_out);
            OFS_STATUS:   rd_data = DATA_W'({st.pid, lvl[2], lvl[1],
                                             fault_any, st.drive, lvl[0]});
            OFS_IRQ_STAT: rd_data = DATA_W'(st.irq_stat);
            OFS_IRQ_MASK: rd_data = DATA_W'(st.irq_mask);
            default:      rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        if (wr_stb && wr_strb[0]) begin
            case (wr_addr)
                OFS_CONFIG:   next_st.cfg = wr_data[CFG_W-1:0]; // [RULE13]
                OFS_SW_OUT:   next_st.sw_out = wr_data[0];
                OFS_IRQ_MASK: next_st.irq_mask = wr_data[EV_W-1:0];
                default:      next_st.cfg = st.cfg;
            endcase
        end
        // Read clears, but a same-cycle event survives
        if (rd_stb && rd_addr == OFS_IRQ_STAT) begin
            next_st.irq_stat = ev;
        end else begin
            next_st.irq_stat = st.irq_stat | ev;
        end
        // Drive gated by enable unless reassigned; nothing else stops [RULE1] [RULE2] [RULE3]
        next_st.drive = st.cfg[CFG_EN_AS_GPI] ? 1'b1 : lvl[0];
        next_st.rep = BASIC_VARIANT && lvl[0]; // [RULE4]
        next_st.fault_q = fault_any;
        next_st.fault_pin = st.cfg[CFG_FLT_AS_GPO] ? st.sw_out : !fault_any; // [RULE5] [RULE8]
        next_st.pid = pid_dec; // [RULE11]
        next_st.seeded = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
            st.cfg[CFG_XDCR_CUR] <= XDCR_CURRENT_OPTION; // [RULE13]
            st.fault_pin <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign SOLENOID_DRIVE_EN  = st.drive;
    assign REPEAT_ENABLE      = st.rep;
    assign FAULT_OUT          = st.fault_pin;
    assign PID_SET            = st.pid;
    assign XDCR_CURRENT_RANGE = st.cfg[CFG_XDCR_CUR];
    assign IRQ                = |(st.irq_stat & st.irq_mask);

    a_drive_follows_en: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
        !st.cfg[CFG_EN_AS_GPI] && !lvl[0] |=> !SOLENOID_DRIVE_EN)
        else $error("Drive on while enable low");
    a_gpi_no_gate: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
        st.cfg[CFG_EN_AS_GPI] |=> SOLENOID_DRIVE_EN)
        else $error("Reassigned enable still gates drive");
    a_repeat_en: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
        BASIC_VARIANT |-> ##1 REPEAT_ENABLE == $past(lvl[0]))
        else $error("Repeat output does not follow enable");
    a_fault_low: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
        fault_any && !st.cfg[CFG_FLT_AS_GPO] |=> !FAULT_OUT)
        else $error("Fault output high during fault");
    a_fault_indep: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
        SOLENOID_SHORT && !lvl[0] && !st.cfg[CFG_FLT_AS_GPO] |=> !FAULT_OUT)
        else $error("Fault hidden while disabled");
    a_gpo_mode: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
        st.cfg[CFG_FLT_AS_GPO] |=> FAULT_OUT == $past(st.sw_out))
        else $error("Fault line ignores software output");
    a_gray_map: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
        st.cfg[CFG_GRAY] && sel == 2'b10 |=> PID_SET == 2'd3)
        else $error("Gray select 10 not set four");
    a_bin_map: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
        !st.cfg[CFG_GRAY] |=> PID_SET == $past(sel))
        else $error("Binary select mismatch");
    a_sf_no_bit1: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
        DUAL_TRANSDUCER_FORCE_VARIANT |-> !sel[1])
        else $error("Second select used on force variant");

    // Steps shared by the decode and bus checks
    sequence s_gray_both_high;
        st.cfg[CFG_GRAY] && sel == 2'b11;
    endsequence
    sequence s_gray_bit0_only;
        st.cfg[CFG_GRAY] && sel == 2'b01;
    endsequence
    sequence s_sel_moved;
        st.seeded && pid_dec != st.pid;
    endsequence
    sequence s_read_waiting;
        RVALID && !RREADY;
    endsequence
    sequence s_write_waiting;
        BVALID && !BREADY;
    endsequence

    a_gray_set3: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
        s_gray_both_high |=> PID_SET == 2'd2)
        else $error("Gray select 11 not set three");
    a_gray_set2: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
        s_gray_bit0_only |=> PID_SET == 2'd1)
        else $error("Gray select 01 not set two");
    a_pid_runtime: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
        s_sel_moved |=> PID_SET != $past(st.pid) && st.irq_stat[EV_PID_CHG])
        else $error("Set change not taken while running");
    a_healthy_high: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
        !fault_any && !st.cfg[CFG_FLT_AS_GPO] |=> FAULT_OUT)
        else $error("Fault output low while healthy");
    a_ref_range_gate: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        REF_CABLE_BROKEN && !REF_CURRENT_RANGE && !SOLENOID_SHORT && !SOLENOID_OPEN
            && !XDCR_CABLE_BROKEN && !st.cfg[CFG_FLT_AS_GPO] |=> FAULT_OUT)
        else $error("Reference break flagged outside current range");
    a_fault_sticky: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        ev[EV_FAULT_SET] |=> st.irq_stat[EV_FAULT_SET])
        else $error("Fault event lost from status");
    a_gpi_still_read: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
        chg[0] |=> st.irq_stat[EV_ENABLE_CHG])
        else $error("Enable change not reported");
    a_regs_live: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
        !lvl[0] && wr_stb && wr_strb[0] && wr_addr == OFS_SW_OUT
            |=> st.sw_out == $past(wr_data[0]))
        else $error("Register write lost while enable low");

    // Bus answers follow each write commit and stand until the master takes them
    a_write_answer: assert property (@(posedge CLK) disable iff (RST)
        wr_stb |=> BVALID)
        else $error("Write commit without response");
    a_bresp_hold: assert property (@(posedge CLK) disable iff (RST)
        s_write_waiting |=> BVALID && $stable(BRESP))
        else $error("Write response dropped before taken");
    a_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
        s_read_waiting |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("Read data dropped before taken");
endmodule
`default_nettype wire

//--- testbench/vdd_mcu_model.sv
// Model of the machine control unit that drives the on-off lines.
// Assumes the bench sets wanted levels; chatter imitates contact bounce.
`timescale 1ns/1ps
`default_nettype none
module vdd_mcu_model (
    input  wire logic       CLK,
    input  wire logic [2:0] want,
    input  wire logic       chatter,
    output var  logic       en_pin,
    output var  logic       sel0_pin,
    output var  logic       sel1_pin
);
    // Lines may change at any time while running
    always @(posedge CLK) begin
        if (chatter) begin
            {sel1_pin, sel0_pin, en_pin} <= ~{sel1_pin, sel0_pin, en_pin};
        end else begin
            {sel1_pin, sel0_pin, en_pin} <= want;
        end
    end
endmodule
`default_nettype wire

//--- testbench/vdd_top_tb.sv
// Self-checking bench for the valve driver discrete I/O block.
// Assumes the fixed 1000-cycle debounce and the register map of vdd_pkg.
`timescale 1ns/1ps
`default_nettype none
module vdd_top_tb;
    import vdd_pkg::*;
    logic              clk, rst, chatter;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [3:0]        wstrb, flt;
    logic [1:0]        bresp, rresp, pid;
    logic [2:0]        want, rv;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rcur;
    logic en_pin, s0_pin, s1_pin, drive, rep, fout, xcur, irq;
    int error_cnt, comparisons, seed, i, k;

    vdd_top u_vdd_top (.CLK(clk), .RST(rst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .ENABLE_IN(en_pin), .PID_SELECT_BIT0(s0_pin), .PID_SELECT_BIT1(s1_pin),
        .SOLENOID_SHORT(flt[0]), .SOLENOID_OPEN(flt[1]),
        .REF_CABLE_BROKEN(flt[2]), .REF_CURRENT_RANGE(rcur),
        .XDCR_CABLE_BROKEN(flt[3]), .SOLENOID_DRIVE_EN(drive),
        .REPEAT_ENABLE(rep), .FAULT_OUT(fout), .PID_SET(pid),
        .XDCR_CURRENT_RANGE(xcur), .IRQ(irq));
    vdd_mcu_model u_vdd_mcu_model (.CLK(clk), .want(want), .chatter(chatter),
        .en_pin(en_pin), .sel0_pin(s0_pin), .sel1_pin(s1_pin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("Error %0t: wait ran out", $time);
        final_report();
    endtask
    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, got;
        int n;
        got = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            got = bvalid;
            if (got) check(32'(bresp), 32'(er));
            @(posedge clk);
            awvalid <= awvalid && !ta;
            wvalid <= wvalid && !tw;
            bready <= !got;
        end
        if (!got) tmo();
    endtask
    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        logic ta, got;
        int n;
        got = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            got = rvalid;
            if (got) rd = rdata;
            if (got) check(32'(rresp), 32'(er));
            @(posedge clk);
            arvalid <= arvalid && !ta;
            rready <= !got;
        end
        if (!got) tmo();
    endtask
    // Bounce first, then a steady level; output must hold until debounce ends
    task automatic pins(input logic [2:0] w);
        @(posedge clk);
        chatter <= 1'b1;
        repeat (300) @(posedge clk);
        chatter <= 1'b0;
        want <= w;
        repeat (900) @(negedge clk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic [1:0] exp_pid(input logic [1:0] s, input logic g);
        if (g && s == 2'h2) return 2'h3;
        if (g && s == 2'h3) return 2'h2;
        return s;
    endfunction
    function automatic logic exp_fout(input logic [3:0] f, input logic c);
        return !(f[0] | f[1] | (f[2] & c) | f[3]);
    endfunction
    task automatic fault_scan();
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            flt <= 4'(1 << (k % 4));
            rcur <= k[2];
            wait_n(3);
            check(32'(fout), 32'(exp_fout(flt, rcur)));
        end
        @(posedge clk);
        flt <= 4'h0;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        tmo();
    end

    initial begin
        seed = 96;
        error_cnt = 0;
        comparisons = 0;
        {rst, awvalid, wvalid, bready, arvalid, rready, chatter} = 7'h40;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h0;
        want = 3'h0;
        flt = 4'h0;
        rcur = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_n(1);
        check(32'({drive, rep, fout, pid, irq}), 32'h08);
        rdr(OFS_CONFIG, RESP_OKAY);
        check(rd, 32'h0);
        wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(OFS_STATUS, 32'h1, RESP_SLVERR);
        pins(3'h1);
        check(32'(drive), 32'h0);
        wait_n(120);
        check(32'({drive, rep, irq}), 32'h7);
        rdr(OFS_IRQ_STAT, RESP_OKAY);
        check(32'(rd[EV_ENABLE_CHG]), 32'h1);
        fault_scan();
        pins(3'h0);
        wait_n(120);
        check(32'({drive, rep}), 32'h0);
        rdr(OFS_STATUS, RESP_OKAY);
        check(32'(rd[ST_ENABLE]), 32'h0);
        fault_scan();
        wr(OFS_CONFIG, 32'h1, RESP_OKAY);
        wait_n(3);
        check(32'(drive), 32'h1);
        @(posedge clk);
        flt <= 4'h1;
        wr(OFS_CONFIG, 32'h2, RESP_OKAY);
        wr(OFS_SW_OUT, 32'h1, RESP_OKAY);
        wait_n(3);
        check(32'(fout), 32'h1);
        wr(OFS_SW_OUT, 32'h0, RESP_OKAY);
        wr(OFS_CONFIG, 32'h8, RESP_OKAY);
        wait_n(3);
        check(32'({fout, xcur, drive}), 32'h2);
        @(posedge clk);
        flt <= 4'h0;
        for (i = 0; i < 12; i++) begin
            rv = (i < 8) ? 3'(i) : 3'($random(seed));
            wr(OFS_CONFIG, 32'(rv[2]) << CFG_GRAY, RESP_OKAY);
            pins({rv[1:0], 1'b0});
            wait_n(120);
            check(32'(pid), 32'(exp_pid(rv[1:0], rv[2])));
        end
        rdr(OFS_IRQ_STAT, RESP_OKAY);
        wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        @(posedge clk);
        flt <= 4'h8;
        wait_n(3);
        check(32'(irq), 32'h0);
        rdr(OFS_IRQ_STAT, RESP_OKAY);
        check(32'(rd[EV_FAULT_SET]), 32'h1);
        rdr(OFS_IRQ_STAT, RESP_OKAY);
        check(32'(rd[EV_FAULT_SET]), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
